// ===== rtl/rwdt_pkg.sv
// Constants and types shared by the runaway watchdog files
package rwdt_pkg;

   // Counter geometry
   localparam int          CNT_W         = 22;
   localparam int          TAP_W         = 2;

   // Register byte addresses on the APB port
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] ADDR_MODE     = 12'h000;
   localparam logic [11:0] ADDR_CMD      = 12'h004;
   localparam logic [11:0] ADDR_STAT     = 12'h008;

   // Command codes written to watchdog_command
   localparam logic [7:0]  CODE_DISABLE  = 8'hb1;
   localparam logic [7:0]  CODE_CLEAR    = 8'h4e;

   // Field positions of watchdog_mode
   localparam int          MODE_EN_BIT   = 7;
   localparam int          MODE_TP_LSB   = 2;
   localparam int          MODE_I2_BIT   = 1;
   localparam int          MODE_RL_BIT   = 0;
   localparam logic [7:0]  MODE_WMASK    = 8'h8f;
   // Enable set, period 00, reset link off, partial_halt_mode run off
   localparam logic [7:0]  MODE_RST      = 8'h80;

   // Field positions of the status register
   localparam int          STAT_RUN_BIT  = 0;
   localparam int          STAT_DIS_BIT  = 1;
   localparam int          STAT_BREL_BIT = 2;
   localparam int          STAT_CNT_LSB  = 8;
   localparam int          STAT_CNT_W    = 8;

   // Overflow masks for taps fsys/2^15, 2^17, 2^19, 2^21
   localparam logic [21:0] TAP_MASK [4]  = '{22'h007fff, 22'h01ffff,
                                             22'h07ffff, 22'h1fffff};

   // Internal reset pulse length in states (pclk cycles)
   localparam int          RST_MIN_ST    = 22;
   localparam int          RST_MAX_ST    = 29;
   localparam int          RST_LEN_W     = 5;
   localparam logic [4:0]  RST_PULSE_CYC = 5'h18;

   // Reset pulse generator states
   typedef enum logic [1:0] {
      RWDT_ST_IDLE  = 2'b01,
      RWDT_ST_PULSE = 2'b10
   } rwdt_rst_state_t;

endpackage

// ===== rtl/rwdt_reset_pulse.sv
// Stretches a watchdog overflow into a fixed-length internal chip reset
`timescale 1ns/1ps
`default_nettype none
module rwdt_reset_pulse (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic trigger,
   output logic      chip_reset
);

   rwdt_pkg::rwdt_rst_state_t state_q;
   rwdt_pkg::rwdt_rst_state_t state_d;
   logic [4:0]                len_q;
   logic [4:0]                len_d;
   logic                      last_w;

   // Last cycle of the pulse reached
   assign last_w = (len_q == rwdt_pkg::RST_PULSE_CYC - 5'h01);

   // Triggers during a pulse are ignored so the length stays fixed
   always_comb begin
      state_d = state_q;
      len_d   = len_q;
      case (state_q)
         rwdt_pkg::RWDT_ST_IDLE: begin
            len_d = 5'h00;
            if (trigger) begin
               state_d = rwdt_pkg::RWDT_ST_PULSE;
            end
         end
         rwdt_pkg::RWDT_ST_PULSE: begin
            len_d = len_q + 5'h01;
            if (last_w) begin
               state_d = rwdt_pkg::RWDT_ST_IDLE;
               len_d   = 5'h00;
            end
         end
         default: begin
            state_d = rwdt_pkg::RWDT_ST_IDLE;
            len_d   = 5'h00;
         end
      endcase
   end

   // State and length registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= rwdt_pkg::RWDT_ST_IDLE;
         len_q   <= 5'h00;
      end else begin
         state_q <= state_d;
         len_q   <= len_d;
      end
   end

   // Output taken from a flop to keep it glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_reset <= 1'b0;
      end else begin
         chip_reset <= (state_d == rwdt_pkg::RWDT_ST_PULSE);
      end
   end

endmodule
`default_nettype wire

// ===== rtl/rwdt_top.sv
// Runaway watchdog: 22-stage counter, APB registers, NMI and reset link
//
// What this block does
// - A 22-bit binary up-counter advances once per pclk while running.
// - The two-bit period select picks the 2^15, 2^17, 2^19 or 2^21 tap.
// - Overflow of the chosen tap pulses the NMI and the timeout output.
// - With reset link set, overflow drives a chip reset of 22..29 cycles.
// - Reset sets the period select to 00, the shortest detection time.
// - Reset sets the enable bit to 1 so counting starts at once.
// - Counting is disabled only after enable is cleared and then B1h is written.
// - Writing the enable bit as 1 restarts a disabled watchdog.
// - Reset clears the reset link bit so overflow alone does not reset.
// - Writing 4Eh to the command register zeroes the counter.
// - The counter holds still in light halt and in stop mode.
// - The counter keeps running while the bus is released.
// - In partial halt the counter runs only with partial_halt_mode run enable set.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module rwdt_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        light_halt_mode,
   input  wire logic        stop_mode,
   input  wire logic        partial_halt_mode,
   input  wire logic        bus_release_ack_n,
   output logic             watchdog_nmi,
   output logic             watchdog_timeout,
   output logic             chip_reset
);

   logic [21:0] cnt_q;
   logic [21:0] cnt_d;
   logic [7:0]  mode_q;
   logic [7:0]  mode_d;
   logic        disabled_q;
   logic        disabled_d;
   logic [31:0] rd_val;

   // APB decode
   wire         setup_w  = psel & penable & ~pready;
   wire         access_w = psel & penable & pready;
   wire         sel_mode = (paddr == rwdt_pkg::ADDR_MODE);
   wire         sel_cmd  = (paddr == rwdt_pkg::ADDR_CMD);
   wire         sel_stat = (paddr == rwdt_pkg::ADDR_STAT);
   wire         mapped_w = sel_mode | sel_cmd | sel_stat;
   wire         wr_mode  = access_w & pwrite & sel_mode;
   wire         wr_cmd   = access_w & pwrite & sel_cmd;
   wire         bad_w    = ~mapped_w | (pwrite & sel_stat);

   // Command decode; unknown codes fall through to nothing
   wire         clr_hit  = wr_cmd & (pwdata[7:0] == rwdt_pkg::CODE_CLEAR);
   wire         dis_hit  = wr_cmd & (pwdata[7:0] == rwdt_pkg::CODE_DISABLE);

   // Mode fields
   wire         en_bit   = mode_q[rwdt_pkg::MODE_EN_BIT];
   wire         i2_bit   = mode_q[rwdt_pkg::MODE_I2_BIT];
   wire         rl_bit   = mode_q[rwdt_pkg::MODE_RL_BIT];
   wire [1:0]   tp_sel   = mode_q[rwdt_pkg::MODE_TP_LSB +: rwdt_pkg::TAP_W];
   wire [21:0]  tap_mask = rwdt_pkg::TAP_MASK[tp_sel];

   // Run gating: bus release is deliberately absent from this term
   wire         halt_w   = light_halt_mode | stop_mode;
   wire         i2_stop  = partial_halt_mode & ~i2_bit;
   wire         run_w    = ~disabled_q & ~halt_w & ~i2_stop;

   // Overflow of the selected tap; the clear write wins over it
   wire         ovf_w    = run_w & ~clr_hit &
                           ((cnt_q & tap_mask) == tap_mask);

   // Counter next value
   assign cnt_d = clr_hit ? 22'h000000 :
                  run_w   ? cnt_q + 22'h000001 : cnt_q;

   // Reserved mode bits stay zero
   assign mode_d = wr_mode ? (pwdata[7:0] & rwdt_pkg::MODE_WMASK) : mode_q;

   // Disable needs enable cleared first; enable write re-arms at once
   assign disabled_d = (wr_mode & pwdata[rwdt_pkg::MODE_EN_BIT]) ? 1'b0 :
                       (dis_hit & ~en_bit) ? 1'b1 :
                       disabled_q;

   // Read mux
   assign rd_val = sel_mode ? {24'h000000, mode_q} :
                   sel_stat ? {16'h0000,
                               cnt_q[rwdt_pkg::CNT_W-1 -: rwdt_pkg::STAT_CNT_W],
                               5'h00, ~bus_release_ack_n,
                               disabled_q, run_w} :
                   32'h00000000;

   // Counter register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 22'h000000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Mode register and disable state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q     <= rwdt_pkg::MODE_RST;
         disabled_q <= 1'b0;
      end else begin
         mode_q     <= mode_d;
         disabled_q <= disabled_d;
      end
   end

   // One wait state: ready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_w;
         pslverr <= setup_w & bad_w;
      end
   end

   // Read data captured before ready so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup_w & ~pwrite) begin
         prdata <= rd_val;
      end
   end

   // Event outputs, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_nmi     <= 1'b0;
         watchdog_timeout <= 1'b0;
      end else begin
         watchdog_nmi     <= ovf_w;
         watchdog_timeout <= ovf_w;
      end
   end

   // Reset link is gated here so the pulse block stays generic
   rwdt_reset_pulse u_rst (
      .pclk       (pclk),
      .presetn    (presetn),
      .trigger    (ovf_w & rl_bit),
      .chip_reset (chip_reset)
   );

   // Helper: length of the current chip reset pulse
   logic [4:0] rst_len_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_len_q <= 5'h00;
      end else if (chip_reset) begin
         rst_len_q <= rst_len_q + 5'h01;
      end else begin
         rst_len_q <= 5'h00;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_count_step: assert property (
      run_w && !clr_hit |=> cnt_q == $past(cnt_q) + 22'h000001)
      else $error("counter did not advance by one");

   chk_tap_ovf: assert property (
      ovf_w |-> (cnt_q & rwdt_pkg::TAP_MASK[tp_sel]) ==
                rwdt_pkg::TAP_MASK[tp_sel] && run_w)
      else $error("overflow at wrong tap");

   chk_nmi_pulse: assert property (
      ovf_w |=> watchdog_nmi && watchdog_timeout ##1 !watchdog_nmi)
      else $error("nmi not a single pulse after overflow");

   chk_reset_len: assert property (
      $fell(chip_reset) |-> rst_len_q >= 5'd22 &&
                            rst_len_q <= 5'd29)
      else $error("chip reset pulse length out of range");

   chk_reset_start: assert property (
      ovf_w && rl_bit && !chip_reset |=> ##1 chip_reset)
      else $error("reset link did not start chip reset");

   chk_no_link: assert property (
      !rl_bit && !chip_reset && !ovf_w |=> !chip_reset)
      else $error("chip reset without reset link");

   chk_disable_seq: assert property (
      $rose(disabled_q) |-> $past(dis_hit) && !$past(en_bit))
      else $error("disabled without proper sequence");

   chk_reenable: assert property (
      wr_mode && pwdata[rwdt_pkg::MODE_EN_BIT] |=> !disabled_q)
      else $error("enable write did not restart watchdog");

   chk_clear_zero: assert property (
      clr_hit |=> cnt_q == 22'h000000)
      else $error("clear code did not zero counter");

   chk_halt_hold: assert property (
      (light_halt_mode || stop_mode) && !clr_hit |=> $stable(cnt_q))
      else $error("counter moved in halt");

   chk_partial_halt_mode_gate: assert property (
      partial_halt_mode && !i2_bit && !clr_hit |=> $stable(cnt_q))
      else $error("counter moved in partial halt");

   chk_busrel_run: assert property (
      !bus_release_ack_n && !disabled_q && !halt_w && !i2_stop && !clr_hit
      |=> cnt_q != $past(cnt_q))
      else $error("counter stopped during bus release");

   chk_other_code: assert property (
      wr_cmd && !clr_hit && !dis_hit |=> $stable(disabled_q))
      else $error("unknown command changed enable state");

   // Bus handshake: one wait state, error only with ready
   chk_ready_wait: assert property (
      psel && penable && !pready |=> pready)
      else $error("ready did not follow first access cycle");

   chk_ready_single: assert property (
      pready |=> !pready)
      else $error("ready stood longer than one cycle");

   chk_err_ready: assert property (
      pslverr |-> pready)
      else $error("error response without ready");

   // Read data only moves in the first access cycle of a read
   chk_prdata_hold: assert property (
      !(psel && penable && !pready && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read");

   // Event outputs stay paired and single
   chk_timeout_match: assert property (
      watchdog_timeout == watchdog_nmi)
      else $error("timeout output differs from nmi");

   chk_nmi_gap: assert property (
      watchdog_nmi |=> !watchdog_nmi)
      else $error("nmi held for two cycles");

   chk_reset_max: assert property (
      rst_len_q <= 5'd29)
      else $error("chip reset pulse too long");

   // Mode register only changes on its own write
   chk_mode_hold: assert property (
      !wr_mode |=> $stable(mode_q))
      else $error("mode changed without a mode write");

   chk_mode_mask: assert property (
      (mode_q & ~rwdt_pkg::MODE_WMASK) == 8'h00)
      else $error("reserved mode bits set");

   // A disabled counter stays put until re-enabled or cleared
   chk_disabled_hold: assert property (
      disabled_q && !wr_mode && !clr_hit |=> $stable(cnt_q))
      else $error("counter moved while disabled");

   chk_partial_halt_mode_run: assert property (
      partial_halt_mode && i2_bit && !disabled_q && !halt_w && !clr_hit
      |=> cnt_q != $past(cnt_q))
      else $error("counter frozen in partial halt with run enable");

   cov_bus_release: cover property (!bus_release_ack_n && run_w);
   cov_overflow: cover property (watchdog_nmi);
   cov_chip_reset: cover property ($fell(chip_reset));
   cov_disable: cover property ($rose(disabled_q));
   cov_clear: cover property (clr_hit);

endmodule
`default_nettype wire

// ===== verif/rwdt_tb_top.sv
// Self-checking testbench for the runaway watchdog block
`timescale 1ns/1ps
`default_nettype none
module rwdt_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        light_halt_mode, stop_mode, partial_halt_mode;
   logic        bus_release_ack_n, er;
   logic        watchdog_nmi, watchdog_timeout, chip_reset;
   logic [7:0]  code;
   int          fail_count, comparisons, cyc, nmi_cyc, nmi_cnt;
   int          rst_len, rst_run, t0;
   integer      seed;

   rwdt_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .light_halt_mode(light_halt_mode), .stop_mode(stop_mode),
      .partial_halt_mode(partial_halt_mode),
      .bus_release_ack_n(bus_release_ack_n), .watchdog_nmi(watchdog_nmi),
      .watchdog_timeout(watchdog_timeout), .chip_reset(chip_reset));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_val(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_range(string nm, int lo, int hi, int g);
      comparisons++;
      if (g < lo || g > hi) begin
         fail_count++;
         $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   // Cycle count, NMI log, reset pulse width; hang guard sized for ~75k
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (watchdog_nmi === 1'b1) begin
         nmi_cyc <= cyc;
         nmi_cnt <= nmi_cnt + 1;
      end
      if (chip_reset === 1'b1) rst_run <= rst_run + 1;
      else if (rst_run != 0) begin
         rst_len <= rst_run;
         rst_run <= 0;
      end
      if (watchdog_timeout !== watchdog_nmi) begin
         chk_val("timeout_out", {31'h0, watchdog_nmi}, {31'h0, watchdog_timeout});
      end
      if (cyc == 90000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic halt_for(int sel, int n);
      light_halt_mode <= (sel == 0);
      stop_mode <= (sel == 1);
      partial_halt_mode <= (sel == 2);
      bus_release_ack_n <= (sel != 3);
      repeat (n) @(posedge pclk);
      {light_halt_mode, stop_mode, partial_halt_mode} <= 3'b000;
      bus_release_ack_n <= 1'b1;
   endtask

   task automatic wait_nmi(int k);
      int n;
      n = 0;
      while (nmi_cnt < k && n < 50000) begin
         @(posedge pclk);
         n++;
      end
   endtask

   initial begin
      seed = 32'he2341291;
      {fail_count, comparisons, cyc, nmi_cyc, nmi_cnt} = '0;
      {rst_len, rst_run} = '0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {light_halt_mode, stop_mode, partial_halt_mode} = 3'b000;
      bus_release_ack_n = 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t0 = cyc;
      // Reset state, unmapped and read-only places
      apb(1'b0, rwdt_pkg::ADDR_MODE, 32'h0);
      chk_val("mode_reset", 32'h80, rd);
      apb(1'b0, 12'h00c, 32'h0);
      chk_val("unmapped_err", 32'h1, {31'h0, er});
      apb(1'b1, rwdt_pkg::ADDR_STAT, 32'h0);
      chk_val("stat_write_err", 32'h1, {31'h0, er});
      $display("test reset_values done");
      // Shortest tap overflows 2^15 cycles after reset, no chip reset
      wait_nmi(1);
      chk_range("first_nmi", 32764, 32772, nmi_cyc - t0);
      chk_val("unlinked_reset", 32'h0, rst_len);
      $display("test first_overflow done");
      // Clear, then halts freeze 9000 cycles, other modes keep counting
      apb(1'b1, rwdt_pkg::ADDR_MODE, 32'h83);
      apb(1'b1, rwdt_pkg::ADDR_CMD, {24'h0, rwdt_pkg::CODE_CLEAR});
      t0 = cyc;
      halt_for(0, 3000);
      halt_for(1, 3000);
      halt_for(2, 3000);
      apb(1'b1, rwdt_pkg::ADDR_MODE, 32'h81);
      halt_for(2, 3000);
      bus_release_ack_n <= 1'b0;
      apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
      chk_val("bus_released", 32'h5, {29'h0, rd[2:0]});
      halt_for(3, 2000);
      wait_nmi(2);
      chk_range("cleared_nmi", 41760, 41772, nmi_cyc - t0);
      repeat (40) @(posedge pclk);
      chk_val("reset_pulse", 32'd24, rst_len);
      $display("test clear_halt_link done");
      // Two-step disable with stray codes, then re-enable
      apb(1'b1, rwdt_pkg::ADDR_MODE, 32'h0);
      for (int i = 0; i < 6; i++) begin
         code = 8'($random(seed));
         if (code == rwdt_pkg::CODE_CLEAR || code == rwdt_pkg::CODE_DISABLE)
            code = code ^ 8'h01;
         apb(1'b1, rwdt_pkg::ADDR_CMD, {24'h0, code});
         apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
         chk_val("stray_code", 32'h1, {30'h0, rd[1:0]});
      end
      apb(1'b1, rwdt_pkg::ADDR_CMD, {24'h0, rwdt_pkg::CODE_DISABLE});
      apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
      chk_val("disabled", 32'h2, {30'h0, rd[1:0]});
      apb(1'b1, rwdt_pkg::ADDR_CMD, 32'h0000005a);
      apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
      chk_val("still_disabled", 32'h2, {30'h0, rd[1:0]});
      apb(1'b1, rwdt_pkg::ADDR_MODE, 32'h80);
      apb(1'b0, rwdt_pkg::ADDR_STAT, 32'h0);
      chk_val("reenabled", 32'h1, {30'h0, rd[1:0]});
      $display("test disable_enable done");
      // Random mode values read back through the writable field mask
      for (int i = 0; i < 6; i++) begin
         code = 8'($random(seed)) | 8'h80;
         apb(1'b1, rwdt_pkg::ADDR_MODE, {24'h0, code});
         apb(1'b0, rwdt_pkg::ADDR_MODE, 32'h0);
         chk_val("mode_rw", {24'h0, code & 8'h8f}, rd);
      end
      apb(1'b0, rwdt_pkg::ADDR_CMD, 32'h0);
      chk_val("cmd_read", 32'h0, rd);
      $display("test mode_readback done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
